// *** design/mqf_pkg.sv ***
package mqf_pkg;
   // bus geometry
   localparam int unsigned QUEUES     = 32;
   localparam int unsigned QBITS      = 5;
   localparam int unsigned QUADS      = 4;
   localparam int unsigned FLAG_W     = 8;
   localparam int unsigned ADDR_W     = 8;
   localparam int unsigned DEV_W      = 3;
   localparam int unsigned DEV_LSB    = 5;
   localparam int unsigned DATA_W     = 18;
   localparam int unsigned QUAD_W     = 2;
   localparam int unsigned PTR_W      = 12;
   localparam int unsigned SEL_DELAY  = 2;
   localparam int unsigned PRS_SETUP  = 2;
   // io level encoding
   localparam logic [1:0]  IO_LVTTL   = 2'h0;
   localparam logic [1:0]  IO_HSTL    = 2'h1;
   localparam logic [1:0]  IO_EHSTL   = 2'h2;
   // register map (byte addresses)
   localparam logic [7:0]  A_CTRL     = 8'h00;
   localparam logic [7:0]  A_STATUS   = 8'h04;
   localparam logic [7:0]  A_IRQ      = 8'h08;
   localparam logic [7:0]  A_MASK     = 8'h0C;
   localparam logic [7:0]  A_SEL      = 8'h10;
   // irq bit positions
   localparam int unsigned IRQ_PRS    = 0;
   localparam int unsigned IRQ_RSEL   = 1;
   localparam int unsigned IRQ_EMPTY  = 2;
   localparam int unsigned IRQ_W      = 3;
   // reset values and bus constants
   localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] ZERO32     = 32'h0000_0000;
   localparam logic [1:0]  HTRANS_NS  = 2'h2;
   localparam logic [1:0]  HRESP_OK   = 2'h0;
   // polled/direct state
   typedef enum logic [1:0] {MQF_DIRECT = 2'b01, MQF_POLLED = 2'b10} mqf_mode_e;
endpackage

// *** design/mqf_sync_stage.sv ***
`timescale 1ns/1ns
// delay line of selectable depth, used for select-to-data alignment
module mqf_sync_stage #(
   parameter int unsigned W = 1,
   parameter int unsigned D = 2
) (
   // clocking
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         ce,
   // data
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] stage [D];

   // shift chain
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < D; i++) begin
            stage[i] <= '0;
         end
      end else if (ce) begin
         stage[0] <= din;
         for (int i = 1; i < D; i++) begin
            stage[i] <= stage[i-1];
         end
      end
   end

   assign dout = stage[D-1];
endmodule

// *** design/mqf_flag_readsel.sv ***
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
// Function
// - almost-full bus shows eight queues, one of four quadrants.
// - flag mode latched from flag_mode_select on the first clock edge after master reset.
// - almost-full bus can be tri-stated for shared expansion.
// - direct mode quadrant picked by strobe, write address and address strobe.
// - polled mode steps quadrants on every write clock edge.
// - HSTL or eHSTL: sleep input gates write data inputs only.
// - LVTTL: sleep input ignored.
// - partial reset clears selected queue pointers only, configuration kept.
// - output data updated with read enable and queue selected, and on the two edges after a select.
// - read address strobe high takes new read queue.
// - low five address bits pick queue, upper three match device id.
// - one more old-queue word, new queue data on second edge.
// - output valid lags selection by two cycles, high when empty.
module mqf_flag_readsel
   import mqf_pkg::*;
#(
   parameter logic [2:0] DEVICE_ID = 3'h0   // arbitrary neutral id
) (
   // clock and reset
   input  wire logic                         hclk,
   input  wire logic                         hresetn,
   input  wire logic                         ce,
   // ahb-lite slave
   input  wire logic                         hsel,
   input  wire logic [31:0]                  haddr,
   input  wire logic [1:0]                   htrans,
   input  wire logic                         hwrite,
   input  wire logic [2:0]                   hsize,
   input  wire logic [31:0]                  hwdata,
   input  wire logic                         hready,
   output logic      [31:0]                  hrdata,
   output logic                              hreadyout,
   output logic      [1:0]                   hresp,
   // configuration straps
   input  wire logic                         flag_mode_select,
   input  wire logic [1:0]                   io_level,
   // write side
   input  wire logic [mqf_pkg::QUEUES-1:0]   almost_full_flag,
   input  wire logic                         full_quadrant_strobe,
   input  wire logic [mqf_pkg::ADDR_W-1:0]   write_queue_address,
   input  wire logic                         write_address_strobe,
   input  wire logic                         input_sleep,
   input  wire logic [mqf_pkg::DATA_W-1:0]   wdata_in,
   output logic      [mqf_pkg::DATA_W-1:0]   wdata_gated,
   output logic      [mqf_pkg::FLAG_W-1:0]   almost_full_flag_bus,
   output logic                              almost_full_flag_bus_oe,
   // partial reset
   input  wire logic                         partial_reset_n,
   output logic                              queue_ptr_clear,
   output logic      [mqf_pkg::QBITS-1:0]    queue_ptr_clear_id,
   // read side
   input  wire logic                         read_address_strobe,
   input  wire logic                         empty_quadrant_strobe,
   input  wire logic [mqf_pkg::ADDR_W-1:0]   read_queue_address,
   input  wire logic                         read_enable_n,
   input  wire logic                         output_enable_n,
   input  wire logic [mqf_pkg::DATA_W-1:0]   queue_rdata,
   input  wire logic                         queue_empty,
   output logic      [mqf_pkg::QBITS-1:0]    read_queue,
   output logic      [mqf_pkg::DATA_W-1:0]   read_data,
   output logic                              read_data_oe,
   output logic                              output_valid_n,
   // interrupt
   output logic                              irq
);
   mqf_mode_e                 mode;
   logic                      in_reset;
   logic [QUAD_W-1:0]         af_quad;
   logic                      wr_dev_hit;
   logic [QBITS-1:0]          wr_queue;
   logic                      rd_selected;
   logic [QBITS-1:0]          rd_prev;
   logic [1:0]                sel_age;
   logic                      sel_fresh;
   logic [FLAG_W-1:0]         af_bus;
   logic [31:0]               ctrl;
   logic [IRQ_W-1:0]          irq_stat;
   logic [IRQ_W-1:0]          irq_mask;
   logic                      ph_valid;
   logic                      ph_write;
   logic [7:0]                ph_addr;
   logic                      prs_seen;

   // quadrant selection and id decode
   wire [DEV_W-1:0]  wr_dev    = write_queue_address[DEV_LSB +: DEV_W];
   wire [DEV_W-1:0]  rd_dev    = read_queue_address[DEV_LSB +: DEV_W];
   wire              rd_hit    = (rd_dev == DEVICE_ID);
   wire              rd_take   = read_address_strobe && rd_hit;
   wire              wr_take   = write_address_strobe && (wr_dev == DEVICE_ID);
   wire              af_strobe = full_quadrant_strobe && (wr_dev == DEVICE_ID);
   wire              sleep_on  = input_sleep && (io_level != IO_LVTTL);
   wire              read_go   = !read_enable_n && rd_selected;
   wire              sw_tristate = ctrl[0];

   // write data gating in low-voltage io modes
   assign wdata_gated = sleep_on ? '0 : wdata_in;

   // quadrant slice of the queue flags
   always_comb begin
      af_bus = '0;
      for (int i = 0; i < FLAG_W; i++) begin
         af_bus[i] = almost_full_flag[{af_quad, 3'(i)}];
      end
   end

   // mode latched on the first enabled edge after master reset releases
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_reset <= 1'b1;
      end else if (ce) begin
         in_reset <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode <= MQF_DIRECT;
      end else if (ce && in_reset) begin
         mode <= flag_mode_select ? MQF_POLLED : MQF_DIRECT;
      end
   end

   // almost-full quadrant pointer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         af_quad <= '0;
      end else if (ce) begin
         case (mode)
            MQF_POLLED: af_quad <= af_quad + 1'b1;
            MQF_DIRECT: begin
               if (af_strobe && write_address_strobe) begin
                  af_quad <= write_queue_address[QUAD_W-1:0];
               end
            end
            default:    af_quad <= '0;
         endcase
      end
   end

   // write queue and device-hit tracking
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_dev_hit <= 1'b1;
         wr_queue   <= '0;
      end else if (ce && write_address_strobe) begin
         wr_dev_hit <= (wr_dev == DEVICE_ID);
         if (wr_take) begin
            wr_queue <= write_queue_address[QBITS-1:0];
         end
      end
   end

   // flag bus registered, tri-stated when not addressed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         almost_full_flag_bus    <= '1;
         almost_full_flag_bus_oe <= 1'b0;
      end else if (ce) begin
         almost_full_flag_bus    <= af_bus;
         almost_full_flag_bus_oe <= wr_dev_hit && !sw_tristate;
      end
   end

   // partial reset: clears one queue's pointers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         queue_ptr_clear    <= 1'b0;
         queue_ptr_clear_id <= '0;
         prs_seen           <= 1'b0;
      end else if (ce) begin
         queue_ptr_clear    <= !partial_reset_n && !prs_seen;
         queue_ptr_clear_id <= wr_queue;
         prs_seen           <= !partial_reset_n;
      end
   end

   // read queue selection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         read_queue  <= '0;
         rd_prev     <= '0;
         rd_selected <= 1'b0;
      end else if (ce) begin
         if (rd_take && !empty_quadrant_strobe) begin
            rd_prev     <= read_queue;
            read_queue  <= read_queue_address[QBITS-1:0];
            rd_selected <= 1'b1;
         end else if (read_address_strobe && !rd_hit) begin
            rd_selected <= 1'b0;
         end
      end
   end

   // select age counter for the two stage lag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_age <= '0;
      end else if (ce) begin
         if (rd_take) begin
            sel_age <= 2'(SEL_DELAY);
         end else if (sel_age != '0) begin
            sel_age <= sel_age - 1'b1;
         end
      end
   end

   // forced word transfer during the two edges after select
   assign sel_fresh = (sel_age != '0);

   // output data register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         read_data <= '0;
      end else if (ce && (read_go || sel_fresh)) begin
         read_data <= queue_rdata;
      end
   end

   assign read_data_oe = !output_enable_n && rd_selected;

   // output valid, aligned to data path
   mqf_sync_stage #(.W(1), .D(SEL_DELAY)) u_ov_lag (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .din     (queue_empty || !rd_selected),                             // no selection, no valid word
      .dout    (output_valid_n)
   );

   // ahb-lite address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_addr  <= '0;
      end else if (ce && hready) begin
         ph_valid <= hsel && (htrans == HTRANS_NS);
         ph_write <= hwrite;
         ph_addr  <= haddr[7:0];
      end
   end

   wire wr_ctrl  = ph_valid && ph_write && (ph_addr == A_CTRL);
   wire wr_mask  = ph_valid && ph_write && (ph_addr == A_MASK);
   wire rd_irq   = ph_valid && !ph_write && (ph_addr == A_IRQ);
   wire [IRQ_W-1:0] irq_evt = {
      sel_age == 2'h1 && queue_empty,
      rd_take,
      queue_ptr_clear
   };

   // control and mask registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl     <= CTRL_RST;
         irq_mask <= '0;
      end else if (ce) begin
         if (wr_ctrl) ctrl <= hwdata;
         if (wr_mask) irq_mask <= hwdata[IRQ_W-1:0];
      end
   end

   // sticky status, read clears, new event wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat <= '0;
      end else if (ce) begin
         irq_stat <= (rd_irq ? '0 : irq_stat) | irq_evt;
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // read mux
   always_comb begin
      hrdata = ZERO32;
      if (ph_valid && !ph_write) begin
         case (ph_addr)
            A_CTRL:   hrdata = ctrl;
            A_STATUS: hrdata = {16'h0000, 3'h0, output_valid_n, mode == MQF_POLLED,
                                af_quad, rd_selected, 3'h0, read_queue};
            A_IRQ:    hrdata = {29'h0000_000, irq_stat};
            A_MASK:   hrdata = {29'h0000_000, irq_mask};
            A_SEL:    hrdata = {24'h00_0000, 3'h0, wr_queue};
            default:  hrdata = ZERO32;
         endcase
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = HRESP_OK;
endmodule

// *** sim/mqf_queue_model.sv ***
`timescale 1ns/1ns
// queue memory stand-in: word holds queue number and a read count
module mqf_queue_model #(
   parameter logic [31:0] AF = 32'h96C3_5AF0
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // read side
   input  wire logic        read_enable_n,
   input  wire logic [4:0]  read_queue,
   output logic      [17:0] queue_rdata,
   output logic             queue_empty,
   output logic      [31:0] almost_full_flag
);
   logic [12:0] count;
   // next word on every enabled read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) count <= 13'h0000;
      else if (!read_enable_n) count <= count + 13'h0001;
   end
   // last queue stays empty so the valid flag can rise
   assign queue_empty      = (read_queue == 5'h1f);
   assign queue_rdata      = {read_queue, count};
   assign almost_full_flag = AF;
endmodule

// *** sim/mqf_flag_readsel_monitor.sv ***
`timescale 1ns/1ns
module mqf_flag_readsel_monitor
   import mqf_pkg::*;
#(
   parameter logic [2:0] DEVICE_ID = 3'h0
) (
   // clocking
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        ce,
   // write side
   input wire logic [1:0]  io_level,
   input wire logic        input_sleep,
   input wire logic [17:0] wdata_in,
   input wire logic [17:0] wdata_gated,
   input wire logic [31:0] almost_full_flag,
   input wire logic        full_quadrant_strobe,
   input wire logic [7:0]  write_queue_address,
   input wire logic        write_address_strobe,
   input wire logic [7:0]  almost_full_flag_bus,
   input wire logic        almost_full_flag_bus_oe,
   input wire logic        partial_reset_n,
   input wire logic        queue_ptr_clear,
   // read side
   input wire logic        read_address_strobe,
   input wire logic        empty_quadrant_strobe,
   input wire logic [7:0]  read_queue_address,
   input wire logic        read_enable_n,
   input wire logic        output_enable_n,
   input wire logic [17:0] queue_rdata,
   input wire logic        queue_empty,
   input wire logic [4:0]  read_queue,
   input wire logic [17:0] read_data,
   input wire logic        read_data_oe,
   input wire logic        output_valid_n
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // a read queue select aimed at this device
   wire sel = read_address_strobe && !empty_quadrant_strobe
              && (read_queue_address[7:5] == DEVICE_ID) && ce;
   a_sleep_gates_data: assert property ((input_sleep && io_level != IO_LVTTL)
      |-> wdata_gated == 18'h0_0000) else $error("write data not gated");
   a_lvttl_ignores_sleep: assert property ((!input_sleep || io_level == IO_LVTTL)
      |-> wdata_gated == wdata_in) else $error("write data not passed");
   a_read_queue_taken: assert property (sel
      |=> read_queue == $past(read_queue_address[4:0])) else $error("read queue not taken");
   a_new_queue_data: assert property (sel
      |-> ##3 read_data == $past(queue_rdata)) else $error("new queue word missing");
   a_idle_read_holds: assert property ((read_enable_n && !$past(sel) && !$past(sel, 2))
      |=> $stable(read_data)) else $error("read data moved without read");
   a_oe_needs_enable: assert property (output_enable_n
      |-> !read_data_oe) else $error("read data driven while disabled");
   a_valid_lags_empty: assert property ($past(queue_empty, 2)
      |-> output_valid_n) else $error("valid flag low on empty queue");
   a_clear_one_pulse: assert property ($fell(partial_reset_n)
      |=> queue_ptr_clear ##1 !queue_ptr_clear) else $error("pointer clear not one pulse");
   a_direct_quadrant: assert property ((full_quadrant_strobe && write_address_strobe
      && write_queue_address[7:5] == DEVICE_ID && ce) |-> ##2 almost_full_flag_bus
      == 8'($past(almost_full_flag) >> (8 * $past(write_queue_address[1:0], 2))))
      else $error("flag bus quadrant wrong");
   a_flag_bus_release: assert property ((write_address_strobe
      && write_queue_address[7:5] != DEVICE_ID) |-> ##[1:2] !almost_full_flag_bus_oe)
      else $error("flag bus still driven");
endmodule
bind mqf_flag_readsel mqf_flag_readsel_monitor #(.DEVICE_ID(DEVICE_ID)) mon (.*);

// *** sim/mqf_flag_readsel_tb.sv ***
`timescale 1ns/1ns
module mqf_flag_readsel_tb;
   import mqf_pkg::*;
   localparam logic [31:0] AF = 32'h96C3_5AF0;
   // bus and clocking
   logic        hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0, hready, hreadyout, irq;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, almost_full_flag;
   logic [1:0]  htrans = 0, hresp, io_level = IO_LVTTL;
   logic [2:0]  hsize = 3'h2;
   // device pins
   logic        flag_mode_select = 0, full_quadrant_strobe = 0, write_address_strobe = 0;
   logic        input_sleep = 0, partial_reset_n = 1, read_address_strobe = 0;
   logic        empty_quadrant_strobe = 0, read_enable_n = 1, output_enable_n = 1;
   logic        almost_full_flag_bus_oe, queue_ptr_clear, queue_empty, read_data_oe;
   logic        output_valid_n;
   logic [7:0]  write_queue_address = 0, read_queue_address = 0, almost_full_flag_bus, keep8;
   logic [17:0] wdata_in = 0, wdata_gated, queue_rdata, read_data, keep;
   logic [4:0]  queue_ptr_clear_id, read_queue;
   int          err_total = 0, tests_run = 0, cyc = 0, k, j;
   assign hready = hreadyout;
   mqf_flag_readsel uut (.*);
   mqf_queue_model #(.AF(AF)) qm (.*);
   // clock and hang guard
   initial forever #20 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         results();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rst(input logic fm);
      @(posedge hclk);
      hresetn <= 1'b0;
      flag_mode_select <= fm;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      #1;
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, HTRANS_NS, wr, 24'h00_0000, a};
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      #1;
   endtask
   task automatic rsel(input logic [2:0] dev, input logic [4:0] q);
      @(posedge hclk);
      read_address_strobe <= 1'b1;
      read_queue_address <= {dev, q};
      @(posedge hclk);
      read_address_strobe <= 1'b0;
      repeat (3) @(posedge hclk);
      #1;
   endtask
   task automatic wsel(input logic fq, input logic [7:0] a);
      @(posedge hclk);
      {full_quadrant_strobe, write_address_strobe, write_queue_address} <= {fq, 1'b1, a};
      @(posedge hclk);
      {full_quadrant_strobe, write_address_strobe} <= 2'b00;
      repeat (3) @(posedge hclk);
      #1;
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      rst(1'b0);
      bus(1'b0, 8'h20, ZERO32);
      check("unmapped read", rd, ZERO32);
      bus(1'b0, A_CTRL, ZERO32);
      check("ctrl reset", rd, CTRL_RST);
      check("bus response", hresp, HRESP_OK);
      bus(1'b1, A_MASK, 32'h0000_0007);
      rsel(3'h0, 5'h03);
      check("read queue", read_queue, 5'h03);
      check("queue word", read_data[17:13], 5'h03);
      check("valid flag", output_valid_n, 1'b0);
      check("irq raised", irq, 1'b1);
      bus(1'b0, A_IRQ, ZERO32);
      check("irq status", rd[IRQ_RSEL], 1'b1);
      check("irq cleared", irq, 1'b0);
      bus(1'b1, A_MASK, ZERO32);
      rsel(3'h0, 5'h04);
      check("irq masked", irq, 1'b0);
      $display("test select and interrupt done");
      keep = read_data;
      repeat (3) @(posedge hclk);
      #1 check("held word", read_data, keep);
      @(posedge hclk);
      {read_enable_n, output_enable_n} <= 2'b00;
      repeat (3) @(posedge hclk);
      #1 check("output enable", read_data_oe, 1'b1);
      check("word advanced", read_data !== keep, 1'b1);
      @(posedge hclk);
      {read_enable_n, output_enable_n} <= 2'b11;
      rsel(3'h5, 5'h04);
      check("foreign id", output_valid_n, 1'b1);
      rsel(3'h0, 5'h1f);
      check("empty queue", output_valid_n, 1'b1);
      $display("test read port done");
      for (k = 0; k < 3; k++) begin
         @(posedge hclk);
         {io_level, input_sleep, wdata_in} <= {k[1:0], 1'b1, 18'h2_5A5A};
         @(posedge hclk);
         #1 check("gated data", wdata_gated, (k == 0) ? 18'h2_5A5A : 18'h0_0000);
      end
      for (k = 0; k < 4; k++) begin
         wsel(1'b1, 8'(k));
         check("flag bus", almost_full_flag_bus, AF[8*k +: 8]);
         check("flag bus drive", almost_full_flag_bus_oe, 1'b1);
      end
      wsel(1'b0, 8'hC0);
      check("flag bus release", almost_full_flag_bus_oe, 1'b0);
      $display("test sleep and direct flags done");
      bus(1'b1, A_SEL, 32'h0000_0007);
      wsel(1'b0, 8'h07);
      rsel(3'h0, 5'h07);
      @(posedge hclk);
      partial_reset_n <= 1'b0;
      @(posedge hclk);
      partial_reset_n <= 1'b1;
      #1 check("clear pulse", queue_ptr_clear, 1'b1);
      check("clear queue", queue_ptr_clear_id, 5'h07);
      $display("test partial reset done");
      rst(1'b1);
      bus(1'b0, A_STATUS, ZERO32);
      check("polled mode bit", rd[11], 1'b1);
      keep8 = almost_full_flag_bus;
      j = -1;
      for (k = 0; k < 4; k++) if (AF[8*k +: 8] === keep8) j = k;
      @(posedge hclk);
      #1 check("polled step", almost_full_flag_bus, AF[8*((j + 1) % 4) +: 8]);
      $display("test polled flags done");
      results();
   end
endmodule
